// [logic/hbd_device.sv]
// device end: register access decode, byte-count, channel dma fifo handshakes
// assumes host obeys strobe protocol; all bus pins are synchronised twice to CLK
module hbd_device
  import hbd_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH,
  parameter int BLOCK = BLOCK_BYTES
) (
  input wire logic CLK, // system clock
  input wire logic RST, // async reset, high
  hbd_if.device BUS, // host-facing pins
  input wire logic DATA_STROBE_STYLE, // strap: data strobe style
  input wire logic INDIRECT_MODE, // strap: indirect addressing
  input wire logic SUBSCRIBER_EQUIPMENT_MODE, // strap: channel a dma pins exist
  input wire logic IRQ_PENDING, // any interrupt pending
  input wire logic [1:0] RX_PUSH_VALID, // receive data arrives per channel
  input wire logic [15:0] RX_PUSH_DATA, // receive byte per channel
  output logic [1:0] TX_POP_VALID, // transmit byte available per channel
  output logic [15:0] TX_POP_DATA, // transmit byte per channel
  input wire logic [1:0] TX_POP_READY, // consumer takes transmit byte
  output logic [7:0] REG_ADDR, // latched register address
  output logic [7:0] REG_WDATA, // register write data
  output logic REG_WRITE, // one-cycle register write pulse
  output logic REG_READ, // one-cycle register read pulse
  input wire logic [7:0] REG_RDATA // register read data
);
  localparam int PW = $clog2(DEPTH);
  // two-flop synchronisers; stage 1 read only by stage 2
  logic [7:0] ad_s1, ad_s2, a_s1, a_s2;
  logic [6:0] c_s1, c_s2;
  logic [6:0] c_prev_reg;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ad_s1 <= 8'h00; ad_s2 <= 8'h00; a_s1 <= 8'h00; a_s2 <= 8'h00;
      c_s1 <= 7'h3F; c_s2 <= 7'h3F; c_prev_reg <= 7'h3F; // latch strobe idles low, else a false muxed cycle
    end else begin
      ad_s1 <= BUS.ad_wire; ad_s2 <= ad_s1;
      a_s1 <= BUS.address_lines; a_s2 <= a_s1;
      c_s1 <= {BUS.ale, BUS.rd_n, BUS.wr_n, BUS.cs_n, BUS.dma_ack_a_n, BUS.dma_ack_b_n, 1'b1};
      c_s2 <= c_s1; c_prev_reg <= c_s2;
    end
  end
  logic ale, rd_n, wr_n, cs_n, ack_a_n, ack_b_n, ale_p, rd_p, wr_p;
  assign {ale, rd_n, wr_n, cs_n, ack_a_n, ack_b_n} = c_s2[6:1];
  assign {ale_p, rd_p, wr_p} = c_prev_reg[6:4];

  // latch strobe seen high once selects multiplexed mode
  logic muxed_reg;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) muxed_reg <= 1'b0;
    else if (ale) muxed_reg <= 1'b1;
  end

  // access begins on strobe assert, ends on strobe release
  logic rd_go, wr_go, acc_start, acc_end, acc_read;
  always_comb begin
    if (DATA_STROBE_STYLE) begin
      acc_start = !rd_n && rd_p; // data strobe falls
      acc_end = rd_n && !rd_p; // rising edge ends access
      acc_read = wr_n; // read/not-write line high means read
    end else begin
      acc_start = (!rd_n && rd_p) || (!wr_n && wr_p);
      acc_end = (rd_n && !rd_p) || (wr_n && !wr_p);
      acc_read = !rd_n || (rd_n && !rd_p);
    end
    rd_go = acc_start && acc_read;
    wr_go = acc_end && !acc_read;
  end

  // address capture: muxed on latch strobe fall, else dedicated lines
  logic [7:0] addr_reg, ind_addr_reg;
  logic [7:0] addr_eff;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) addr_reg <= DATA_RESET;
    else if (!ale && ale_p) addr_reg <= ad_s2;
  end
  always_comb begin
    if (muxed_reg) addr_eff = addr_reg;
    else if (INDIRECT_MODE) addr_eff = {7'h00, a_s2[0]}; // only A0 decoded
    else addr_eff = a_s2;
  end

  // select: chip select for registers, ack replaces it for fifos
  logic reg_sel, ack_a, ack_b;
  assign ack_a = !ack_a_n && SUBSCRIBER_EQUIPMENT_MODE;
  assign ack_b = !ack_b_n;
  assign reg_sel = !cs_n && !ack_a && !ack_b;

  // indirect mode: address port holds pointer, data port accesses it
  logic [7:0] target;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) ind_addr_reg <= DATA_RESET;
    else if (reg_sel && wr_go && INDIRECT_MODE && addr_eff == ADDR_INDIRECT_ADDR) ind_addr_reg <= ad_s2;
  end
  assign target = (INDIRECT_MODE && !muxed_reg) ? ind_addr_reg : addr_eff;

  // per-channel fifos, byte count and requests
  logic [7:0] rx_mem [CHANNELS][DEPTH];
  logic [7:0] tx_mem [CHANNELS][DEPTH];
  logic [PW:0] rx_wp [CHANNELS], rx_rp [CHANNELS], tx_wp [CHANNELS], tx_rp [CHANNELS];
  logic [COUNT_W-1:0] tx_left [CHANNELS];
  logic [6:0] blk_left [CHANNELS];
  logic [7:0] rd_byte;
  logic [1:0] tx_req, rx_req;
  logic [7:0] cnt_lo_reg;

  function automatic logic [6:0] rx_block(input logic [PW:0] fill);
    if (fill >= (PW+1)'(64)) rx_block = 7'd64;
    else if (fill >= (PW+1)'(32)) rx_block = 7'd32;
    else if (fill >= (PW+1)'(16)) rx_block = 7'd16;
    else if (fill >= (PW+1)'(8)) rx_block = 7'd8;
    else if (fill >= (PW+1)'(4)) rx_block = 7'd4;
    else rx_block = 7'd0;
  endfunction : rx_block

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) cnt_lo_reg <= DATA_RESET;
    else if (reg_sel && wr_go && target == ADDR_TX_COUNT_LOW) cnt_lo_reg <= ad_s2;
  end

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_ch
      logic ack, rx_pop, tx_push;
      logic [PW:0] rx_fill, tx_fill;
      assign ack = (g == 0) ? ack_a : ack_b;
      assign rx_pop = ack && rd_go;
      assign tx_push = ack && wr_go && (tx_left[g] != '0);
      assign rx_fill = rx_wp[g] - rx_rp[g];
      assign tx_fill = tx_wp[g] - tx_rp[g];
      always_ff @(posedge CLK) begin
        if (RX_PUSH_VALID[g] && rx_fill != (PW+1)'(DEPTH)) rx_mem[g][rx_wp[g][PW-1:0]] <= RX_PUSH_DATA[g*8 +: 8];
        if (tx_push) tx_mem[g][tx_wp[g][PW-1:0]] <= ad_s2;
      end
      always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
          rx_wp[g] <= '0; rx_rp[g] <= '0; tx_wp[g] <= '0; tx_rp[g] <= '0;
        end else begin
          if (RX_PUSH_VALID[g] && rx_fill != (PW+1)'(DEPTH)) rx_wp[g] <= rx_wp[g] + 1'b1;
          if (rx_pop && rx_fill != '0) rx_rp[g] <= rx_rp[g] + 1'b1;
          if (tx_push) tx_wp[g] <= tx_wp[g] + 1'b1;
          if (TX_POP_VALID[g] && TX_POP_READY[g]) tx_rp[g] <= tx_rp[g] + 1'b1;
        end
      end
      // tx: count programmed by high byte write (channel b only), blocks of 64 then remainder
      always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
          tx_left[g] <= '0; tx_req[g] <= 1'b0;
        end else if (reg_sel && wr_go && target == ADDR_TX_COUNT_HIGH && hbd_chan_t'(g) == HBD_CH_B) begin
          tx_left[g] <= {ad_s2[COUNT_W-9:0], cnt_lo_reg};
        end else begin
          if (tx_push) tx_left[g] <= tx_left[g] - 1'b1;
          // drop at the last write of a block; raise when room for next block
          if (tx_push && (tx_left[g] == 1 || (tx_fill + 1'b1) % BLOCK == 0)) tx_req[g] <= 1'b0;
          // re-raise only once the acknowledge clears, else the controller never sees the block end
          else if (!tx_req[g] && !ack && tx_left[g] != '0 && (PW+1)'(DEPTH) - tx_fill >= (PW+1)'(BLOCK))
            tx_req[g] <= 1'b1;
        end
      end
      // rx: block size chosen at raise, drops after its last read
      always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
          rx_req[g] <= 1'b0; blk_left[g] <= '0;
        end else if (rx_req[g]) begin
          if (rx_pop) begin
            blk_left[g] <= blk_left[g] - 1'b1;
            if (blk_left[g] == 7'd1) rx_req[g] <= 1'b0;
          end
        end else if (rx_block(rx_fill) != 7'd0 && !ack) begin
          rx_req[g] <= 1'b1;
          blk_left[g] <= rx_block(rx_fill);
        end
      end
      assign TX_POP_VALID[g] = tx_fill != '0;
      assign TX_POP_DATA[g*8 +: 8] = tx_mem[g][tx_rp[g][PW-1:0]];
    end
  endgenerate

  // channel a pins exist only in subscriber mode
  assign BUS.dma_tx_req_a = tx_req[0] && SUBSCRIBER_EQUIPMENT_MODE;
  assign BUS.dma_rx_req_a = rx_req[0] && SUBSCRIBER_EQUIPMENT_MODE;
  assign BUS.dma_tx_req_b = tx_req[1];
  assign BUS.dma_rx_req_b = rx_req[1];

  // read data: fifo top under ack, else register file
  always_comb begin
    if (ack_b) rd_byte = rx_mem[1][rx_rp[1][PW-1:0]];
    else if (ack_a) rd_byte = rx_mem[0][rx_rp[0][PW-1:0]];
    else rd_byte = REG_RDATA;
  end
  logic drive_reg;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      BUS.ad_dev <= DATA_RESET; drive_reg <= 1'b0;
    end else begin
      if (rd_go && (reg_sel || ack_a || ack_b)) BUS.ad_dev <= rd_byte;
      else if (REG_READ) BUS.ad_dev <= REG_RDATA; // register data follows REG_ADDR by one cycle
      if (rd_go && (reg_sel || ack_a || ack_b)) drive_reg <= 1'b1;
      else if (acc_end) drive_reg <= 1'b0;
    end
  end
  assign BUS.ad_dev_oe_n = !drive_reg;

  // register side strobes
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      REG_ADDR <= DATA_RESET; REG_WDATA <= DATA_RESET; REG_WRITE <= 1'b0; REG_READ <= 1'b0;
    end else begin
      REG_WRITE <= reg_sel && wr_go && !(INDIRECT_MODE && addr_eff == ADDR_INDIRECT_ADDR);
      REG_READ <= reg_sel && rd_go;
      if (reg_sel && (rd_go || wr_go)) REG_ADDR <= target;
      if (reg_sel && wr_go) REG_WDATA <= ad_s2;
    end
  end

  // open drain: only ever pulls low
  assign BUS.int_n_out = 1'b0;
  assign BUS.int_n_oe_n = !IRQ_PENDING;
endmodule : hbd_device

// [shared/hbd_pkg.sv]
// package for the host bus / dma port: constants and state types shared by both ends
// assumes one clock (CLK, 125 MHz) drives both ends; the bus is modelled as sampled pins
// Contract
// - muxed mode: address then data on shared lines
// - non-muxed mode: address on separate lines
// - indirect mode decodes only lowest address bit
// - separate strobes: read strobe reads, write writes
// - data strobe rising edge ends access
// - host drives read/not-write high read, low write
// - device answers only while chip select low
// - host holds latch strobe high during address
// - latch strobe selects muxed or non-muxed mode
// - interrupt open-drain, low while pending
// - tx request high while tx fifo needs data
// - host programs tx byte count first
// - tx moves 64-byte blocks plus remainder
// - tx request drops after last write falls
// - rx request high while rx fifo needs emptying
// - rx request drops after last read falls
// - channel a requests only in subscriber mode
// - dma controller drives acknowledge low when master
// - acknowledge with strobe replaces chip select
// - acknowledge ignores address lines, selects fifo
package hbd_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int BLOCK_BYTES = 64;
  localparam int COUNT_W = 12;
  localparam int FIFO_DEPTH = 128;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] ADDR_TX_COUNT_LOW = 8'h00;
  localparam logic [7:0] ADDR_TX_COUNT_HIGH = 8'h01;
  localparam logic [7:0] ADDR_INDIRECT_DATA = 8'h01;
  localparam logic [7:0] ADDR_INDIRECT_ADDR = 8'h00;
  localparam int CHANNELS = 2;
  typedef enum logic {HBD_CH_A, HBD_CH_B} hbd_chan_t;
  typedef enum {HBD_IDLE, HBD_ADDR, HBD_STROBE, HBD_DONE} hbd_state_t;
endpackage : hbd_pkg

// [shared/hbd_if.sv]
// interface joining host end and device end of the parallel port
// assumes both ends share CLK; open-drain interrupt is resolved in int_n_wire
interface hbd_if;
  import hbd_pkg::*;
  logic [7:0] ad_host; // host drive of shared/data lines
  logic ad_host_oe_n; // host drives lines when low
  logic [7:0] ad_dev; // device drive of data lines
  logic ad_dev_oe_n; // device drives lines when low
  logic [7:0] address_lines; // dedicated address inputs
  logic ale; // address latch strobe
  logic rd_n; // read strobe or data strobe
  logic wr_n; // write strobe or read/not-write
  logic cs_n; // chip select
  logic int_n_out; // device open-drain pull value
  logic int_n_oe_n; // device pulls interrupt low when low
  logic dma_tx_req_a;
  logic dma_rx_req_a;
  logic dma_tx_req_b;
  logic dma_rx_req_b;
  logic dma_ack_a_n;
  logic dma_ack_b_n;
  logic [7:0] ad_wire;
  logic int_n_wire;
  assign ad_wire = !ad_dev_oe_n ? ad_dev : (!ad_host_oe_n ? ad_host : 8'hFF);
  assign int_n_wire = int_n_oe_n ? 1'b1 : int_n_out;
  modport device (input ad_wire, ad_host, address_lines, ale, rd_n, wr_n, cs_n, dma_ack_a_n, dma_ack_b_n,
    output ad_dev, ad_dev_oe_n, int_n_out, int_n_oe_n, dma_tx_req_a, dma_rx_req_a, dma_tx_req_b, dma_rx_req_b);
  modport host (input ad_wire, ad_dev, int_n_wire, dma_tx_req_a, dma_rx_req_a, dma_tx_req_b, dma_rx_req_b,
    output ad_host, ad_host_oe_n, address_lines, ale, rd_n, wr_n, cs_n, dma_ack_a_n, dma_ack_b_n);
endinterface : hbd_if

// [logic/hbd_host.sv]
// host end: runs one register or dma access per request on the pin bus
// assumes the device samples pins through two flops, so the address and strobe phases hold 2*PHASE cycles each, the closing phase PHASE
module hbd_host
  import hbd_pkg::*;
#(
  parameter int PHASE = 4
) (
  input wire logic CLK, // system clock
  input wire logic RST, // async reset, high
  hbd_if.host BUS, // device-facing pins
  input wire logic MUXED, // use shared lines for address
  input wire logic DATA_STROBE_STYLE, // data strobe style
  input wire logic REQ_VALID, // start an access
  output logic REQ_READY, // idle, accepts request
  input wire logic REQ_WRITE, // 1 write, 0 read
  input wire logic [1:0] REQ_DMA, // 0 register, 1 channel a, 2 channel b
  input wire logic [7:0] REQ_ADDR, // register address
  input wire logic [7:0] REQ_WDATA, // write byte
  output logic RSP_VALID, // one-cycle read/done pulse
  output logic [7:0] RSP_RDATA, // read byte
  output logic IRQ // interrupt seen low on the wire
);
  hbd_state_t state_reg;
  logic [7:0] cnt_reg;
  logic wr_reg;
  logic [1:0] dma_reg;
  logic [7:0] addr_reg, data_reg;
  logic [1:0] irq_s;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_reg <= HBD_IDLE; cnt_reg <= 8'h00; wr_reg <= 1'b0; dma_reg <= 2'h0;
      addr_reg <= 8'h00; data_reg <= 8'h00; RSP_VALID <= 1'b0; RSP_RDATA <= 8'h00;
    end else begin
      RSP_VALID <= 1'b0;
      cnt_reg <= cnt_reg + 8'h01;
      case (state_reg)
        HBD_IDLE: begin
          cnt_reg <= 8'h00;
          if (REQ_VALID) begin
            wr_reg <= REQ_WRITE; dma_reg <= REQ_DMA; addr_reg <= REQ_ADDR; data_reg <= REQ_WDATA;
            state_reg <= (MUXED && REQ_DMA == 2'h0) ? HBD_ADDR : HBD_STROBE;
          end
        end
        HBD_ADDR: if (cnt_reg == 8'(2*PHASE - 1)) begin
          state_reg <= HBD_STROBE; cnt_reg <= 8'h00;
        end
        HBD_STROBE: if (cnt_reg == 8'(2*PHASE - 1)) begin
          state_reg <= HBD_DONE; cnt_reg <= 8'h00;
          RSP_RDATA <= BUS.ad_wire;
        end
        default: if (cnt_reg == 8'(PHASE - 1)) begin
          state_reg <= HBD_IDLE; RSP_VALID <= 1'b1;
        end
      endcase
    end
  end
  assign REQ_READY = state_reg == HBD_IDLE;

  logic strobe;
  assign strobe = state_reg == HBD_STROBE;
  // latch strobe high only while the address sits on the shared lines
  assign BUS.ale = MUXED && state_reg == HBD_ADDR && cnt_reg < 8'(PHASE);
  assign BUS.address_lines = MUXED ? 8'hFF : addr_reg;
  assign BUS.ad_host = (state_reg == HBD_ADDR) ? addr_reg : data_reg;
  assign BUS.ad_host_oe_n = !(state_reg == HBD_ADDR || ((strobe || state_reg == HBD_DONE) && wr_reg));
  assign BUS.cs_n = !((strobe || state_reg == HBD_DONE) && dma_reg == 2'h0);
  assign BUS.dma_ack_a_n = !(state_reg != HBD_IDLE && dma_reg == 2'h1);
  assign BUS.dma_ack_b_n = !(state_reg != HBD_IDLE && dma_reg == 2'h2);
  always_comb begin
    if (DATA_STROBE_STYLE) begin
      BUS.rd_n = !strobe; // data strobe
      BUS.wr_n = !wr_reg; // read/not-write: high read
    end else begin
      BUS.rd_n = !(strobe && !wr_reg);
      BUS.wr_n = !(strobe && wr_reg);
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) irq_s <= 2'b00;
    else irq_s <= {irq_s[0], !BUS.int_n_wire};
  end
  assign IRQ = irq_s[1];
endmodule : hbd_host

// [test/hbd_assertions.sv]
// checker for the pin interface between the host end and the device end
// assumes one clock; the bench instantiates it beside the interface
module hbd_assertions (
  input wire logic CLK, // clock
  input wire logic RST, // async reset, high
  input wire logic ad_host_oe_n, // host drives lines when low
  input wire logic ad_dev_oe_n, // device drives lines when low
  input wire logic ale, // address latch strobe
  input wire logic rd_n, // read or data strobe
  input wire logic wr_n, // write or read/not-write
  input wire logic cs_n, // chip select
  input wire logic int_n_out, // interrupt pull value
  input wire logic int_n_oe_n, // interrupt pull enable
  input wire logic dma_tx_req_a, // tx request a
  input wire logic dma_rx_req_a, // rx request a
  input wire logic dma_tx_req_b, // tx request b
  input wire logic dma_rx_req_b, // rx request b
  input wire logic dma_ack_a_n, // acknowledge a
  input wire logic dma_ack_b_n // acknowledge b
);
  logic ack;
  logic [3:0] wr_age_reg;
  logic [3:0] rd_age_reg;
  logic [3:0] sel_age_reg;
  assign ack = !dma_ack_a_n || !dma_ack_b_n;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // ages saturate so a long idle never wraps into a false recent access
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) wr_age_reg <= 4'hf;
    else if (ack && !wr_n) wr_age_reg <= 4'h0;
    else if (wr_age_reg != 4'hf) wr_age_reg <= wr_age_reg + 4'h1;
  end
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) rd_age_reg <= 4'hf;
    else if (ack && !rd_n && wr_n) rd_age_reg <= 4'h0;
    else if (rd_age_reg != 4'hf) rd_age_reg <= rd_age_reg + 4'h1;
  end
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) sel_age_reg <= 4'hf;
    else if ((!cs_n || ack) && !rd_n) sel_age_reg <= 4'h0;
    else if (sel_age_reg != 4'hf) sel_age_reg <= sel_age_reg + 4'h1;
  end
  int_pull_a: assert property (!int_n_oe_n |-> !int_n_out) else $error("interrupt pulled high");
  dev_read_only_a: assert property (!ad_dev_oe_n |-> wr_n) else $error("device drives during write");
  dev_selected_a: assert property (!ad_dev_oe_n |-> sel_age_reg < 4'h8) else $error("unselected drive");
  no_contention_a: assert property (!(!ad_dev_oe_n && !ad_host_oe_n)) else $error("both ends drive");
  tx_b_drop_a: assert property ($fell(dma_tx_req_b) |-> wr_age_reg < 4'h8) else $error("tx b dropped idle");
  tx_a_drop_a: assert property ($fell(dma_tx_req_a) |-> wr_age_reg < 4'h8) else $error("tx a dropped idle");
  rx_b_drop_a: assert property ($fell(dma_rx_req_b) |-> rd_age_reg < 4'h8) else $error("rx b dropped idle");
  rx_a_drop_a: assert property ($fell(dma_rx_req_a) |-> rd_age_reg < 4'h8) else $error("rx a dropped idle");
  ale_addr_a: assert property (ale |-> !ad_host_oe_n) else $error("latch strobe without address");
  strobe_sel_a: assert property (!rd_n |-> !cs_n || ack) else $error("strobe without select");
  one_ack_a: assert property (!(!dma_ack_a_n && !dma_ack_b_n)) else $error("two acknowledges");
endmodule : hbd_assertions

// [test/tb_host_bus_dma_port.sv]
// bench: host end and device end joined by the interface, with a queue model of the fifos
// assumes package and interface compiled first; REG_RDATA is modelled as address xor a5
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin failures++; $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tb_host_bus_dma_port
  import hbd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, dstyle = 1'b0, muxed = 1'b0, indirect = 1'b0, subscr = 1'b0, irq_p = 1'b0;
  logic rq_v = 1'b0, rq_w = 1'b0, rq_rdy, rs_v, irq, reg_wr, reg_rd;
  logic [1:0] rq_dma = 2'h0, rx_v = 2'h0, tx_v, tx_rdy = 2'h0;
  logic [7:0] rq_a = 8'h00, rq_d = 8'h00, rs_d, reg_a, reg_d, reg_rdata, wr_addr, wr_data, txe;
  logic [15:0] rx_d = 16'h0000, tx_d;
  logic [7:0] rxq[$], txq[$];
  int failures = 0, check_count = 0, seed = 32'h2cbb, pend = 0, reads = 0;
  assign reg_rdata = reg_a ^ 8'ha5;
  always #4 clk = ~clk;
  hbd_if bus_if ();
  hbd_host hbd_host_inst (.CLK(clk), .RST(rst), .BUS(bus_if), .MUXED(muxed), .DATA_STROBE_STYLE(dstyle),
    .REQ_VALID(rq_v), .REQ_READY(rq_rdy), .REQ_WRITE(rq_w), .REQ_DMA(rq_dma), .REQ_ADDR(rq_a), .REQ_WDATA(rq_d),
    .RSP_VALID(rs_v), .RSP_RDATA(rs_d), .IRQ(irq));
  hbd_device hbd_device_inst (.CLK(clk), .RST(rst), .BUS(bus_if), .DATA_STROBE_STYLE(dstyle),
    .INDIRECT_MODE(indirect), .SUBSCRIBER_EQUIPMENT_MODE(subscr), .IRQ_PENDING(irq_p), .RX_PUSH_VALID(rx_v),
    .RX_PUSH_DATA(rx_d), .TX_POP_VALID(tx_v), .TX_POP_DATA(tx_d), .TX_POP_READY(tx_rdy), .REG_ADDR(reg_a),
    .REG_WDATA(reg_d), .REG_WRITE(reg_wr), .REG_READ(reg_rd), .REG_RDATA(reg_rdata));
  hbd_assertions hbd_assertions_inst (.CLK(clk), .RST(rst), .ad_host_oe_n(bus_if.ad_host_oe_n),
    .ad_dev_oe_n(bus_if.ad_dev_oe_n), .ale(bus_if.ale), .rd_n(bus_if.rd_n), .wr_n(bus_if.wr_n), .cs_n(bus_if.cs_n),
    .int_n_out(bus_if.int_n_out), .int_n_oe_n(bus_if.int_n_oe_n), .dma_tx_req_a(bus_if.dma_tx_req_a),
    .dma_rx_req_a(bus_if.dma_rx_req_a), .dma_tx_req_b(bus_if.dma_tx_req_b), .dma_rx_req_b(bus_if.dma_rx_req_b),
    .dma_ack_a_n(bus_if.dma_ack_a_n), .dma_ack_b_n(bus_if.dma_ack_b_n));
  always @(posedge clk) begin
    if (reg_rd) reads++;
    if (reg_wr) begin
      wr_addr <= reg_a;
      wr_data <= reg_d;
    end
    if (tx_v[1] && tx_rdy[1] && txq.size() > 0) begin
      txe = txq.pop_front();
      `CHK("tx byte", txe, tx_d[15:8])
    end
  end
  task automatic stop_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  task automatic access(input logic wr, input logic [1:0] dma, input logic [7:0] a, d, output logic [7:0] r);
    @(negedge clk);
    while (!rq_rdy) @(negedge clk);
    rq_v = 1'b1;
    rq_w = wr;
    rq_dma = dma;
    rq_a = a;
    rq_d = d;
    @(negedge clk);
    rq_v = 1'b0;
    repeat (200) begin
      @(posedge clk);
      #1;
      if (rs_v) break;
    end
    `CHK("response", 1'b1, rs_v)
    r = rs_d;
  endtask : access
  task automatic reg_pair(input logic [7:0] a, d);
    logic [7:0] r;
    int n0;
    access(1'b1, 2'h0, a, d, r);
    repeat (3) @(negedge clk);
    `CHK("write addr", a, wr_addr)
    `CHK("write data", d, wr_data)
    n0 = reads;
    access(1'b0, 2'h0, a, 8'h00, r);
    `CHK("read data", a ^ 8'ha5, r)
    `CHK("read pulse", n0 + 1, reads)
  endtask : reg_pair
  task automatic push_rx(input int ch);
    logic [7:0] d;
    d = 8'($random(seed));
    rxq.push_back(d);
    // the request picks its block size when it rises, and it rises at the fourth byte
    if (pend == 0 && rxq.size() >= 4) pend = blk(rxq.size());
    @(negedge clk);
    rx_v = 2'(1 << ch);
    rx_d = {d, d};
    @(negedge clk);
    rx_v = 2'h0;
  endtask : push_rx
  function automatic logic req_of(int ch, logic wr);
    return wr ? (ch ? bus_if.dma_tx_req_b : bus_if.dma_tx_req_a) : (ch ? bus_if.dma_rx_req_b : bus_if.dma_rx_req_a);
  endfunction : req_of
  function automatic int blk(int n);
    for (int b = BLOCK_BYTES; b >= 4; b = b / 2) if (n >= b) return b;
    return 0;
  endfunction : blk
  // one request episode: accesses run until the device withdraws its request
  task automatic burst(input int ch, input logic wr, output int n);
    logic [7:0] d, r;
    n = 0;
    repeat (60) if (!req_of(ch, wr)) @(negedge clk);
    while (req_of(ch, wr) && n < 200) begin
      d = 8'($random(seed));
      if (wr) txq.push_back(d);
      access(wr, 2'(ch + 1), 8'($random(seed)), d, r);
      if (!wr) begin
        d = rxq.pop_front();
        `CHK("rx byte", d, r)
      end
      n++;
    end
  endtask : burst
  initial begin
    int n;
    int sent;
    logic [7:0] p, r;
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    for (int m = 0; m < 2; m++) begin
      dstyle = m[0];
      repeat (3) reg_pair(8'h20 | 8'($random(seed) & 63), 8'($random(seed)));
    end
    for (int i = 0; i < 8; i++) push_rx(0);
    repeat (20) @(negedge clk);
    `CHK("rx req a off", 1'b0, bus_if.dma_rx_req_a)
    subscr = 1'b1;
    for (int ch = 0; ch < 2; ch++) begin
      for (int i = (ch ? 0 : 8); i < 40; i++) push_rx(ch);
      while (rxq.size() >= 4) begin
        sent = pend;
        burst(ch, 1'b0, n);
        `CHK("rx block", sent, n)
        pend = blk(rxq.size());
      end
    end
    access(1'b1, 2'h0, ADDR_TX_COUNT_LOW, 8'h46, r);
    access(1'b1, 2'h0, ADDR_TX_COUNT_HIGH, 8'h00, r);
    sent = 0;
    // the consumer stalls so each block ends at a 64-byte fifo fill boundary or at the end of the count
    while (sent < 70) begin
      burst(1, 1'b1, n);
      `CHK("tx block", (70 - sent > BLOCK_BYTES) ? BLOCK_BYTES : 70 - sent, n)
      sent += (n > 0) ? n : 70;
    end
    tx_rdy = 2'h3;
    repeat (300) if (txq.size() != 0) @(negedge clk);
    `CHK("tx drained", 0, txq.size())
    `CHK("tx req idle", 1'b0, bus_if.dma_tx_req_b)
    irq_p = 1'b1;
    repeat (8) @(negedge clk);
    `CHK("irq wire", 1'b0, bus_if.int_n_wire)
    `CHK("irq seen", 1'b1, irq)
    irq_p = 1'b0;
    repeat (8) @(negedge clk);
    `CHK("irq clear", 1'b0, irq)
    indirect = 1'b1;
    p = 8'h40 | 8'($random(seed) & 63);
    access(1'b1, 2'h0, 8'h10, p, r);
    access(1'b0, 2'h0, 8'hf1, 8'h00, r);
    `CHK("indirect read", p ^ 8'ha5, r)
    access(1'b1, 2'h0, 8'h23, 8'h5a, r);
    repeat (3) @(negedge clk);
    `CHK("indirect write", p, wr_addr)
    indirect = 1'b0;
    muxed = 1'b1;
    repeat (3) reg_pair(8'h20 | 8'($random(seed) & 63), 8'($random(seed)));
    stop_test();
  end
  // about 3000 cycles are expected; the margin covers slow strobe phases
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    stop_test();
  end
endmodule : tb_host_bus_dma_port
